// ### rtl/capture_wave_pkg.sv
package capture_wave_pkg;

    localparam int NCH = 8;
    localparam int TW  = 16;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_TIMER  = 8'h04;
    localparam logic [7:0] OFF_GATE   = 8'h08;
    localparam logic [7:0] OFF_FILT   = 8'h0C;
    localparam logic [7:0] OFF_EDGE   = 8'h10;
    localparam logic [7:0] OFF_MODE   = 8'h14;
    localparam logic [7:0] OFF_OUTCFG = 8'h18;
    localparam logic [7:0] OFF_RTP    = 8'h1C;
    localparam logic [7:0] OFF_DEB    = 8'h20;
    localparam logic [7:0] OFF_SER    = 8'h24;
    localparam logic [7:0] OFF_CMP    = 8'h40;
    localparam logic [7:0] OFF_CAP    = 8'h60;
    localparam logic [7:0] OFF_PSC    = 8'h80;

    // control field positions
    localparam int CTRL_RUN  = 0;
    localparam int CTRL_RST0 = 1;
    localparam int CTRL_SRC8 = 2;
    localparam int CTRL_FCLK = 3;
    localparam int CTRL_DEB  = 4;
    localparam int CTRL_W    = 5;

    // gate, output setup and serial register fields
    localparam int GATE_REL_LSB = 8;
    localparam int GATE_ST_LSB  = 16;
    localparam int OUT_INV_LSB  = 8;
    localparam int SER_BUSY_BIT = 8;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST   = 5'h00;
    localparam logic [15:0]       EDGE_RST   = 16'h5555;
    localparam logic [7:0]        DEB_W_RST  = 8'h00;

    // cycle counts and the bit-modulation period width in bits
    localparam logic [1:0] BT_RST_DELAY = 2'h2;
    localparam logic [2:0] F8_LAST      = 3'h7;
    localparam logic [3:0] SER_BITS     = 4'h8;
    localparam int         BITMOD_PER_W = 6;

    typedef enum logic [2:0] {
        M_OFF, M_SINGLE, M_TOGGLE, M_SR, M_BITMOD, M_RTP, M_PRTP, M_PHASE
    } mode_t;

endpackage : capture_wave_pkg

// ### rtl/timer_capture_waveform_unit.sv
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - filter passes a level only after three equal samples on selected clock
// - with gating on, triggers after the first accepted one are ignored
// - gating ends on software release or same-channel compare match
// - after gating ends the next trigger captures the base timer
// - every accepted trigger stores the base timer into the capture register
// - 8-bit prescaler: capture on every setting-plus-one trigger, up to 256
// - debounce down-counter decrements once per eighth-rate clock edge
// - each level change on debounced pin reloads the filter width
// - level passes on first eighth-rate edge after counter is zero
// - timer equal compare gives match pulse, interrupt request and output update
// - single-phase: high on match, low when base timer reaches zero
// - toggle mode inverts the output on every match
// - set/reset: even register sets, next register or timer zero clears
// - software default level holds before the first match
// - optional inversion before the output pin
// - reset on compare 0: timer becomes zero two clocks after equality
// - bit-modulation PWM: 64-clock period, 6-bit low width, 10-bit extension count
// - timed port: match on channel j drives pin j with buffer bit j
// - parallel timed port: match on any parallel-mode channel moves its buffer bits to all parallel-mode pins
// - phase shift: compare 0 match raises the output at the phase pointer and steps it; timer zero clears outputs and pointer
// - channel 2 in toggle mode makes the serial clock
// - writing the transmit buffer shifts data out on the serial pin
// - base timer is a 16-bit free-running up counter on its count source
// - each accepted trigger raises a time-measurement request
// - trigger polarity per channel: rising, falling or both
module timer_capture_waveform_unit
    import capture_wave_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic                 pready,
    output logic [31:0]          prdata,
    output logic                 pslverr,
    input  wire logic [NCH-1:0]  channel_io_pin,
    output logic [NCH-1:0]       group2_waveform_pin,
    output logic [NCH-1:0]       capture_req,
    output logic [NCH-1:0]       match_req,
    output logic                 serial_transmit_pin
);

    typedef struct packed {
        logic [CTRL_W-1:0]       ctrl;
        logic [NCH-1:0]          gate_en;
        logic [NCH-1:0]          filt_en;
        logic [15:0]             edge_sel;
        logic [NCH-1:0][2:0]     mode;
        logic [NCH-1:0]          dflt;
        logic [NCH-1:0]          inv;
        logic [NCH-1:0]          timed_port_output;
        logic [7:0]              deb_w;
        logic [NCH-1:0][TW-1:0]  cmp;
        logic [NCH-1:0][TW-1:0]  cap;
        logic [NCH-1:0][7:0]     psc;
        logic [NCH-1:0][7:0]     pcnt;
        logic [TW-1:0]           bt;
        logic                    fresh;
        logic [1:0]              rpend;
        logic [2:0]              div;
        logic [NCH-1:0]          lvl_prev;
        logic [NCH-1:0]          gated;
        logic [NCH-1:0]          wave;
        logic [NCH-1:0]          pin_out;
        logic [NCH-1:0]          cap_req;
        logic [NCH-1:0]          match_req;
        logic                    deb_raw;
        logic [7:0]              deb_cnt;
        logic                    deb_out;
        logic [2:0]              phase_ptr;
        logic [7:0]              sh;
        logic [3:0]              sh_cnt;
        logic                    sclk_prev;
        logic                    txd;
        logic                    pready;
        logic [31:0]             prdata;
        logic                    pslverr;
    } unit_t;

    unit_t          s_q;
    unit_t          s_d;
    logic [1:0]     rst_sync_q;
    logic           rst_core_n;
    logic [NCH-1:0] cond_lvl;
    logic           f8_tick;
    logic           bt_tick;

    // reset is asserted at once and released through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_q[1];

    assign f8_tick = (s_q.div == F8_LAST);
    assign bt_tick = s_q.ctrl[CTRL_RUN] && (!s_q.ctrl[CTRL_SRC8] || f8_tick);

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_cond
            trigger_conditioner u_cond (
                .clk         (clk),
                .rst_n       (rst_core_n),
                .pin         (channel_io_pin[g]),
                .filt_en     (s_q.filt_en[g]),
                .sample_tick (s_q.ctrl[CTRL_FCLK] ? bt_tick : 1'b1),
                .level       (cond_lvl[g])
            );
        end
    endgenerate

    logic [NCH-1:0] lvl;
    logic [NCH-1:0] trig;
    logic [NCH-1:0] match;
    logic           zero;
    logic           prtp_hit;
    logic           acc;
    logic           wr;
    logic [6:0]     bm_low;
    logic [7:0]     a;
    logic [2:0]     ai;

    always_comb begin
        s_d       = s_q;
        lvl       = cond_lvl;
        trig      = '0;
        match     = '0;
        prtp_hit  = 1'b0;
        bm_low    = '0;
        a         = paddr;
        ai        = paddr[4:2];
        acc       = psel && penable;
        wr        = acc && s_q.pready && pwrite;

        s_d.div   = s_q.div + 3'h1;

        // debounce on the last channel pin, counted on the eighth-rate clock
        s_d.deb_raw = cond_lvl[NCH-1];
        if (s_q.deb_raw != cond_lvl[NCH-1]) begin
            s_d.deb_cnt = s_q.deb_w;
        end else if (f8_tick) begin
            if (s_q.deb_cnt == 8'h00) begin
                s_d.deb_out = s_q.deb_raw;
            end else begin
                s_d.deb_cnt = s_q.deb_cnt - 8'h01;
            end
        end
        if (s_q.ctrl[CTRL_DEB]) begin
            lvl[NCH-1] = s_q.deb_out;
        end

        // base timer; a match or zero only counts on the cycle the value is new
        s_d.fresh = bt_tick;
        zero      = s_q.fresh && (s_q.bt == '0);
        for (int j = 0; j < NCH; j++) begin
            match[j] = s_q.fresh && (s_q.bt == s_q.cmp[j]);
        end
        if (bt_tick) begin
            if (s_q.rpend == 2'h1) begin
                s_d.bt    = '0;
                s_d.rpend = 2'h0;
            end else begin
                s_d.bt = s_q.bt + 16'h0001;
                if (s_q.rpend != 2'h0) begin
                    s_d.rpend = s_q.rpend - 2'h1;
                end
            end
        end
        if (match[0] && s_q.ctrl[CTRL_RST0]) begin
            s_d.rpend = BT_RST_DELAY - (bt_tick ? 2'h1 : 2'h0);
        end

        // time measurement
        s_d.lvl_prev = lvl;
        s_d.cap_req  = '0;
        for (int j = 0; j < NCH; j++) begin
            trig[j] = (lvl[j] && !s_q.lvl_prev[j] && s_q.edge_sel[2*j]) ||
                      (!lvl[j] && s_q.lvl_prev[j] && s_q.edge_sel[2*j+1]);
            if (match[j] || (wr && a == OFF_GATE && pwdata[GATE_REL_LSB+j])) begin
                s_d.gated[j] = 1'b0;
            end
            if (trig[j] && !s_q.gated[j]) begin
                if (s_q.pcnt[j] == 8'h00) begin
                    s_d.cap[j]     = s_q.bt;
                    s_d.cap_req[j] = 1'b1;
                    s_d.pcnt[j]    = s_q.psc[j];
                    s_d.gated[j]   = s_q.gate_en[j];
                end else begin
                    s_d.pcnt[j] = s_q.pcnt[j] - 8'h01;
                end
            end
        end

        // waveform generation
        s_d.match_req = match;
        if (zero) begin
            s_d.phase_ptr = '0;
        end else if (match[0]) begin
            s_d.phase_ptr = s_q.phase_ptr + 3'h1;
        end
        for (int j = 0; j < NCH; j++) begin
            prtp_hit = prtp_hit || (match[j] && mode_t'(s_q.mode[j]) == M_PRTP);
        end
        for (int j = 0; j < NCH; j++) begin
            bm_low = {1'b0, s_q.cmp[j][TW-1:TW-BITMOD_PER_W]} +
                     {6'h00, (s_q.bt[TW-1:BITMOD_PER_W] < s_q.cmp[j][TW-BITMOD_PER_W-1:0])};
            unique case (mode_t'(s_q.mode[j]))
                M_OFF: begin
                    s_d.wave[j] = s_q.wave[j];
                end
                M_SINGLE: begin
                    if (match[j]) begin
                        s_d.wave[j] = 1'b1;
                    end else if (zero) begin
                        s_d.wave[j] = 1'b0;
                    end
                end
                M_TOGGLE: begin
                    if (match[j]) begin
                        s_d.wave[j] = !s_q.wave[j];
                    end
                end
                M_SR: begin
                    if (j % 2 == 0) begin
                        if (match[j]) begin
                            s_d.wave[j] = 1'b1;
                        end else if (match[(j+1)%NCH] || zero) begin
                            s_d.wave[j] = 1'b0;
                        end
                    end
                end
                M_BITMOD: begin
                    // low part first, then high for the rest of the 64 clocks
                    s_d.wave[j] = ({1'b0, s_q.bt[BITMOD_PER_W-1:0]} >= bm_low);
                end
                M_RTP: begin
                    if (match[j]) begin
                        s_d.wave[j] = s_q.timed_port_output[j];
                    end
                end
                M_PRTP: begin
                    if (prtp_hit) begin
                        s_d.wave[j] = s_q.timed_port_output[j];
                    end
                end
                M_PHASE: begin
                    if (zero) begin
                        s_d.wave[j] = 1'b0;
                    end else if (match[0] && s_q.phase_ptr == 3'(j)) begin
                        s_d.wave[j] = 1'b1;
                    end
                end
            endcase
        end

        // serial transmit: shifts on falling edge of channel 2, receiver samples on rising
        s_d.sclk_prev = s_q.wave[2];
        if (s_q.sh_cnt != 4'h0 && s_q.sclk_prev && !s_q.wave[2]) begin
            s_d.txd    = s_q.sh[0];
            s_d.sh     = {1'b1, s_q.sh[7:1]};
            s_d.sh_cnt = s_q.sh_cnt - 4'h1;
        end else if (s_q.sh_cnt == 4'h0 && s_q.sclk_prev && !s_q.wave[2]) begin
            s_d.txd = 1'b1;
        end
        if (wr && a == OFF_SER && s_q.sh_cnt == 4'h0) begin
            s_d.sh     = pwdata[7:0];
            s_d.sh_cnt = SER_BITS;
        end

        // register writes; a write of the output setup reloads the default level
        if (wr) begin
            unique case (1'b1)
                a == OFF_CTRL:   s_d.ctrl     = pwdata[CTRL_W-1:0];
                a == OFF_GATE:   s_d.gate_en  = pwdata[NCH-1:0];
                a == OFF_FILT:   s_d.filt_en  = pwdata[NCH-1:0];
                a == OFF_EDGE:   s_d.edge_sel = pwdata[15:0];
                a == OFF_MODE:   s_d.mode     = pwdata[3*NCH-1:0];
                a == OFF_OUTCFG: begin
                    s_d.dflt = pwdata[NCH-1:0];
                    s_d.inv  = pwdata[OUT_INV_LSB+:NCH];
                    s_d.wave = pwdata[NCH-1:0];
                end
                a == OFF_RTP:    s_d.timed_port_output      = pwdata[NCH-1:0];
                a == OFF_DEB:    s_d.deb_w    = pwdata[7:0];
                a[7:5] == OFF_CMP[7:5]: s_d.cmp[ai] = pwdata[TW-1:0];
                a[7:5] == OFF_PSC[7:5]: begin
                    s_d.psc[ai]  = pwdata[7:0];
                    s_d.pcnt[ai] = '0;
                end
                default: begin
                    s_d.ctrl = s_q.ctrl;
                end
            endcase
        end
        s_d.pin_out = s_d.wave ^ s_d.inv;

        // one wait state: answer is registered on the first access cycle
        s_d.pready  = acc && !s_q.pready;
        s_d.prdata  = '0;
        s_d.pslverr = 1'b0;
        if (acc && !s_q.pready) begin
            unique case (1'b1)
                a == OFF_CTRL:   s_d.prdata = {27'h0, s_q.ctrl};
                a == OFF_TIMER:  s_d.prdata = {16'h0, s_q.bt};
                a == OFF_GATE:   s_d.prdata = {8'h0, s_q.gated, 8'h0, s_q.gate_en};
                a == OFF_FILT:   s_d.prdata = {24'h0, s_q.filt_en};
                a == OFF_EDGE:   s_d.prdata = {16'h0, s_q.edge_sel};
                a == OFF_MODE:   s_d.prdata = {8'h0, s_q.mode};
                a == OFF_OUTCFG: s_d.prdata = {8'h0, s_q.pin_out, s_q.inv, s_q.dflt};
                a == OFF_RTP:    s_d.prdata = {24'h0, s_q.timed_port_output};
                a == OFF_DEB:    s_d.prdata = {16'h0, s_q.deb_cnt, s_q.deb_w};
                a == OFF_SER:    s_d.prdata = {23'h0, (s_q.sh_cnt != 4'h0), s_q.sh};
                a[7:5] == OFF_CMP[7:5]: s_d.prdata = {16'h0, s_q.cmp[ai]};
                a[7:5] == OFF_CAP[7:5]: s_d.prdata = {16'h0, s_q.cap[ai]};
                a[7:5] == OFF_PSC[7:5]: s_d.prdata = {24'h0, s_q.psc[ai]};
                default: s_d.pslverr = 1'b1;
            endcase
            if (a[1:0] != 2'h0) begin
                s_d.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            s_q          <= '0;
            s_q.ctrl     <= CTRL_RST;
            s_q.edge_sel <= EDGE_RST;
            s_q.deb_w    <= DEB_W_RST;
            s_q.sh       <= 8'hFF;
            s_q.txd      <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready              = s_q.pready;
    assign prdata              = s_q.prdata;
    assign pslverr             = s_q.pslverr;
    assign group2_waveform_pin = s_q.pin_out;
    assign capture_req         = s_q.cap_req;
    assign match_req           = s_q.match_req;
    assign serial_transmit_pin = s_q.txd;

endmodule : timer_capture_waveform_unit

// ### rtl/trigger_conditioner.sv
`timescale 1ns/10ps
module trigger_conditioner
    import capture_wave_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    input  wire logic filt_en,
    input  wire logic sample_tick,
    output logic      level
);

    typedef struct packed {
        logic [1:0] sync;
        logic [2:0] hist;
        logic       lvl;
    } cond_t;

    cond_t s_q;
    cond_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.sync = {s_q.sync[0], pin};
        if (sample_tick) begin
            s_d.hist = {s_q.hist[1:0], s_q.sync[1]};
        end
        // same three-sample wait for both directions keeps timestamp differences exact
        if (!filt_en) begin
            s_d.lvl = s_q.sync[1];
        end else if ((&s_d.hist) || !(|s_d.hist)) begin
            s_d.lvl = s_d.hist[0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.lvl;

endmodule : trigger_conditioner

// ### test/pin_driver.sv
`timescale 1ns/10ps
module pin_driver
    import capture_wave_pkg::*;
(
    input  wire logic           clk,
    output logic     [NCH-1:0] pins
);
    // pins are asynchronous on the device, edge-driven here only to make widths exact
    initial pins = 8'h00;

    task automatic set(input int ch, input logic v);
        @(posedge clk);
        pins[ch] <= v;
    endtask : set

    task automatic pulse(input int ch, input int w);
        set(ch, 1'b1);
        repeat (w - 1) @(posedge clk);
        set(ch, 1'b0);
    endtask : pulse
endmodule : pin_driver

// ### test/tcwu_props.sv
`timescale 1ns/10ps
module tcwu_props
    import capture_wave_pkg::*;
(
    input wire logic           clk,
    input wire logic           rst_n,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pready,
    input wire logic [31:0]    prdata,
    input wire logic           pslverr,
    input wire logic [NCH-1:0] group2_waveform_pin,
    input wire logic [NCH-1:0] capture_req,
    input wire logic [NCH-1:0] match_req,
    input wire logic           serial_transmit_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_apb_wait: assert property (psel && penable && !$past(penable) |-> !pready)
        else $error("ready without wait state");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    chk_cap_pulse: assert property ((capture_req & $past(capture_req)) == 8'h0)
        else $error("capture request longer than one cycle");
    chk_match_pulse: assert property ((match_req & $past(match_req)) == 8'h0)
        else $error("match request longer than one cycle");
    // a zero bit may land one cycle after the clock edge, so two samples back are allowed
    chk_ser_fall: assert property ($fell(serial_transmit_pin) |-> !group2_waveform_pin[2] &&
        ($past(group2_waveform_pin[2]) || $past(group2_waveform_pin[2], 2)))
        else $error("serial bit not on falling clock");
endmodule : tcwu_props

bind timer_capture_waveform_unit tcwu_props tcwu_props_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .group2_waveform_pin(group2_waveform_pin), .capture_req(capture_req),
    .match_req(match_req), .serial_transmit_pin(serial_transmit_pin)
);

// ### test/test_timer_capture_waveform_unit.sv
`timescale 1ns/10ps
module test_timer_capture_waveform_unit
    import capture_wave_pkg::*;
;
    logic           clk;
    logic           rst_n;
    logic           psel;
    logic           penable;
    logic           pwrite;
    logic [7:0]     paddr;
    logic [31:0]    pwdata;
    logic           pready;
    logic [31:0]    prdata;
    logic           pslverr;
    logic [NCH-1:0] pins;
    logic [NCH-1:0] wave;
    logic [NCH-1:0] cap;
    logic [NCH-1:0] mat;
    logic           ser;
    logic [31:0]    rdat;
    logic           rerr;
    int             fails;
    int             n_checks;
    int             n;
    int             cap_cnt [NCH];

    timer_capture_waveform_unit timer_capture_waveform_unit_i (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .channel_io_pin(pins), .group2_waveform_pin(wave), .capture_req(cap),
        .match_req(mat), .serial_transmit_pin(ser)
    );
    pin_driver pin_driver_i (.clk(clk), .pins(pins));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        for (int k = 0; k < NCH; k++) begin
            if (cap[k] === 1'b1) begin
                cap_cnt[k] <= cap_cnt[k] + 1;
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        // ready is looked at mid-cycle, the transfer completes at the next rising edge
        do begin
            @(negedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            fails++;
            wrap_up();
        end
        rdat = prdata;
        rerr = pslverr;
        @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // sel 0 capture, 1 match, 2 waveform level; n returns the cycles spent
    task automatic wait_on(input int sel, input int ch, input logic v);
        logic s;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            s = sel == 0 ? cap[ch] : sel == 1 ? mat[ch] : wave[ch];
        end while (s !== v && n < 500);
        if (n >= 500) begin
            fails++;
            wrap_up();
        end
    endtask : wait_on

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset

    task automatic s_regs;
        apb(1'b0, OFF_EDGE, 32'h0);
        check(rdat, 32'h5555);
        apb(1'b0, OFF_CTRL, 32'h0);
        check(rdat, 32'h0);
        apb(1'b0, 8'hFC, 32'h0);
        check({rdat[30:0], rerr}, 32'h1);
    endtask : s_regs

    task automatic s_stamp(input logic [7:0] filt);
        logic [31:0] c1;
        apb(1'b1, OFF_FILT, {24'h0, filt});
        fork
            pin_driver_i.pulse(0, 40);
            begin
                wait_on(0, 0, 1'b1);
                apb(1'b0, OFF_CAP, 32'h0);
                c1 = rdat;
            end
        join
        wait_on(0, 0, 1'b1);
        apb(1'b0, OFF_CAP, 32'h0);
        check((rdat - c1) & 32'hFFFF, 32'h28);
    endtask : s_stamp

    task automatic s_filter;
        apb(1'b1, OFF_FILT, 32'h2);
        pin_driver_i.pulse(1, 2);
        repeat (20) @(posedge clk);
        check(cap_cnt[1], 32'h0);
        pin_driver_i.pulse(1, 3);
        repeat (20) @(posedge clk);
        check(cap_cnt[1], 32'h1);
    endtask : s_filter

    task automatic s_presc;
        apb(1'b1, OFF_PSC + 8'h08, 32'h2);
        repeat (7) begin
            pin_driver_i.pulse(2, 4);
            repeat (6) @(posedge clk);
        end
        repeat (10) @(posedge clk);
        check(cap_cnt[2], 32'h3);
    endtask : s_presc

    task automatic s_deb;
        apb(1'b1, OFF_DEB, 32'h2);
        apb(1'b1, OFF_CTRL, 32'h11);
        pin_driver_i.pulse(7, 4);
        repeat (40) @(posedge clk);
        check(cap_cnt[7], 32'h0);
        pin_driver_i.pulse(7, 60);
        repeat (40) @(posedge clk);
        check(cap_cnt[7], 32'h1);
    endtask : s_deb

    task automatic s_gate;
        apb(1'b1, OFF_GATE, 32'h8);
        repeat (3) begin
            pin_driver_i.pulse(3, 4);
            repeat (6) @(posedge clk);
        end
        repeat (10) @(posedge clk);
        check(cap_cnt[3], 32'h1);
        apb(1'b0, OFF_GATE, 32'h0);
        check(rdat[19], 1'b1);
        apb(1'b1, OFF_GATE, 32'h808);
        pin_driver_i.pulse(3, 4);
        repeat (10) @(posedge clk);
        check(cap_cnt[3], 32'h2);
    endtask : s_gate

    task automatic s_wave;
        logic p;
        apb(1'b1, OFF_CMP, 32'h63);
        apb(1'b1, OFF_CMP + 8'h08, 32'h0A);
        apb(1'b1, OFF_CMP + 8'h10, 32'h32);
        apb(1'b1, OFF_CMP + 8'h14, 32'h1E);
        apb(1'b1, OFF_CMP + 8'h18, 32'h46);
        apb(1'b1, OFF_MODE, 32'h0014A080);
        apb(1'b1, OFF_RTP, 32'h40);
        apb(1'b1, OFF_OUTCFG, 32'h2000);
        repeat (3) @(negedge clk);
        check(wave[5], 1'b1);
        apb(1'b1, OFF_CTRL, 32'h3);
        wait_on(1, 0, 1'b1);
        wait_on(1, 0, 1'b1);
        check(n, 32'h65);
        wait_on(1, 4, 1'b1);
        p = wave[4];
        wait_on(1, 4, 1'b1);
        check(wave[4] ^ p, 1'b1);
        wait_on(1, 5, 1'b1);
        @(negedge clk);
        check(wave[5], 1'b0);
        wait_on(1, 0, 1'b1);
        repeat (4) @(negedge clk);
        check(wave[5], 1'b1);
        wait_on(1, 6, 1'b1);
        @(negedge clk);
        check(wave[6], 1'b1);
    endtask : s_wave

    task automatic s_serial;
        logic [7:0] d;
        apb(1'b1, OFF_SER, 32'hA5);
        apb(1'b0, OFF_SER, 32'h0);
        check(rdat[8], 1'b1);
        wait_on(2, 2, 1'b1);
        wait_on(2, 2, 1'b0);
        for (int i = 0; i < 8; i++) begin
            wait_on(2, 2, 1'b1);
            d[i] = ser;
            wait_on(2, 2, 1'b0);
        end
        check(d, 8'hA5);
    endtask : s_serial

    initial begin
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        fails    = 0;
        n_checks = 0;
        foreach (cap_cnt[k]) cap_cnt[k] = 0;
        do_reset();
        s_regs();
        apb(1'b1, OFF_EDGE, 32'h5557);
        apb(1'b1, OFF_CTRL, 32'h1);
        s_stamp(8'h00);
        s_stamp(8'h01);
        s_filter();
        s_presc();
        s_gate();
        s_deb();
        // second reset restarts the timer at zero before the compare period is set
        do_reset();
        s_wave();
        s_serial();
        wrap_up();
    end
endmodule : test_timer_capture_waveform_unit
